/* rtl/apllcr_pkg.sv */
// Constants, register map and address decode for the analog PLL control register bank.
package apllcr_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Register indexes; the byte address on the bus is four times the index.
	localparam logic [9:0] IDX_LOOP_CFG = 10'h068;
	localparam logic [9:0] IDX_MODE_CFG = 10'h069;
	localparam logic [9:0] IDX_VCO_CFG = 10'h06a;
	localparam logic [9:0] IDX_RSVD = 10'h06b;
	localparam logic [9:0] IDX_STATUS = 10'h080;
	// Field positions.
	localparam int POS_PUMP = 5;
	localparam int POS_RES = 3;
	localparam int POS_CAP = 1;
	localparam int POS_POLE = 0;
	localparam int POS_TDC = 4;
	localparam int POS_XO = 3;
	localparam int POS_CNTW = 1;
	localparam int POS_MAN = 0;
	localparam int POS_OSC = 5;
	localparam int POS_CODE = 0;
	localparam int POS_ST_MAN = 0;
	localparam int POS_ST_XO = 1;
	localparam int POS_ST_OSCBAD = 2;
	// Values after reset.
	localparam logic [2:0] RST_PUMP = 3'h4;
	localparam logic [1:0] RST_RES = 2'h1;
	localparam logic [1:0] RST_CAP = 2'h1;
	localparam logic RST_POLE = 1'h1;
	localparam logic RST_TDC = 1'h0;
	localparam logic RST_XO = 1'h0;
	localparam logic RST_CNTW = 1'h1;
	localparam logic RST_MAN = 1'h0;
	localparam logic [2:0] RST_OSC = 3'h1;
	localparam logic [4:0] RST_CODE = 5'h0b;
	// Lock accumulator lengths, oscillator codes and bus response codes.
	localparam logic [4:0] LOCK_BITS_WIDE = 5'h14;
	localparam logic [4:0] LOCK_BITS_NARROW = 5'h10;
	localparam logic [2:0] OSC_FIRST = 3'h0;
	localparam logic [2:0] OSC_SECOND = 3'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {SEL_NONE, SEL_LOOP, SEL_MODE, SEL_VCO, SEL_RSVD, SEL_STATUS} apllcr_sel_e;

	function automatic apllcr_sel_e apllcr_decode(input logic [ADDR_W-1:0] addr);
		apllcr_sel_e sel;
		sel = SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			case (addr[ADDR_W-1:2])
				IDX_LOOP_CFG: sel = SEL_LOOP;
				IDX_MODE_CFG: sel = SEL_MODE;
				IDX_VCO_CFG: sel = SEL_VCO;
				IDX_RSVD: sel = SEL_RSVD;
				IDX_STATUS: sel = SEL_STATUS;
				default: sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction
endpackage

/* rtl/apllcr_wr_join.sv */
// AXI4-Lite write channel: joins address and data in either order and returns the response.
module apllcr_wr_join (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [apllcr_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [apllcr_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [1:0] wr_resp,
	output logic wr_en,
	output logic [apllcr_pkg::ADDR_W-1:0] wr_addr,
	output logic [apllcr_pkg::DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [apllcr_pkg::ADDR_W-1:0] addr;
		logic [apllcr_pkg::DATA_W-1:0] data;
		logic [3:0] strb;
		logic bvalid;
		logic [1:0] bresp;
	} apllcr_wr_s;

	apllcr_wr_s st, next_st;

	always_comb begin
		next_st = st;
		wr_en = 1'b0;
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.addr = awaddr;
		end
		if (wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.data = wdata;
			next_st.strb = wstrb;
		end
		// The store waits for a free response slot so that no answer is overwritten.
		if (st.aw_held && st.w_held && !st.bvalid) begin
			wr_en = 1'b1;
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_resp;
		end
		next_st.awready = !next_st.aw_held && !next_st.bvalid;
		next_st.wready = !next_st.w_held && !next_st.bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '{awready: 1'b1, wready: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign awready = st.awready;
	assign wready = st.wready;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign wr_addr = st.addr;
	assign wr_data = st.data;
	assign wr_strb = st.strb;
endmodule // apllcr_wr_join

/* rtl/apllcr_rd_port.sv */
// AXI4-Lite read channel: takes one address and returns registered read data.
module apllcr_rd_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [apllcr_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [apllcr_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic rd_en,
	input wire logic [apllcr_pkg::DATA_W-1:0] rd_data,
	input wire logic [1:0] rd_resp
);
	typedef struct packed {
		logic arready;
		logic rvalid;
		logic [apllcr_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} apllcr_rd_s;

	apllcr_rd_s st, next_st;

	always_comb begin
		next_st = st;
		rd_en = arvalid && st.arready;
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rd_en) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_data;
			next_st.rresp = rd_resp;
		end
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '{arready: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign arready = st.arready;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
endmodule // apllcr_rd_port

/* rtl/apllcr_regs.sv */
// Analog PLL control register bank with AXI4-Lite access and decoded control outputs.

module apllcr_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [apllcr_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [apllcr_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [apllcr_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [apllcr_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [2:0] pump_current_sel,
	output logic [3:0] pump_current_steps,
	output logic [1:0] filter_series_res_sel,
	output logic [1:0] filter_par_cap_sel,
	output logic second_pole_sel,
	output logic time_digitizer_off,
	output logic time_digitizer_en,
	output logic crystal_only_synth,
	output logic jitter_atten_en,
	output logic lock_counter_width,
	output logic [4:0] lock_count_bits,
	output logic lock_manual_override,
	output logic [2:0] manual_osc_pick,
	output logic osc_second_sel,
	output logic osc_reserved,
	output logic [4:0] manual_lock_code,
	output logic [4:0] lock_code_force
);
	typedef struct packed {
		logic [2:0] pump;
		logic [1:0] res;
		logic [1:0] cap;
		logic pole;
		logic tdc_off;
		logic xo;
		logic cntw;
		logic man;
		logic [2:0] osc;
		logic [4:0] code;
		logic [3:0] pump_steps;
		logic tdc_en;
		logic jit_en;
		logic [4:0] lock_bits;
		logic osc_second;
		logic osc_bad;
		logic [4:0] code_force;
	} apllcr_state_s;

	localparam apllcr_state_s ST_RESET = '{
		pump: apllcr_pkg::RST_PUMP,
		res: apllcr_pkg::RST_RES,
		cap: apllcr_pkg::RST_CAP,
		pole: apllcr_pkg::RST_POLE,
		tdc_off: apllcr_pkg::RST_TDC,
		xo: apllcr_pkg::RST_XO,
		cntw: apllcr_pkg::RST_CNTW,
		man: apllcr_pkg::RST_MAN,
		osc: apllcr_pkg::RST_OSC,
		code: apllcr_pkg::RST_CODE,
		pump_steps: 4'({1'b0, apllcr_pkg::RST_PUMP} + 4'h1),
		tdc_en: !apllcr_pkg::RST_TDC,
		jit_en: !apllcr_pkg::RST_XO,
		lock_bits: apllcr_pkg::RST_CNTW ? apllcr_pkg::LOCK_BITS_NARROW : apllcr_pkg::LOCK_BITS_WIDE,
		osc_second: apllcr_pkg::RST_OSC == apllcr_pkg::OSC_SECOND,
		osc_bad: apllcr_pkg::RST_OSC > apllcr_pkg::OSC_SECOND,
		code_force: apllcr_pkg::RST_MAN ? apllcr_pkg::RST_CODE : 5'h00
	};

	apllcr_state_s st, next_st;
	logic wr_en;
	logic rd_en;
	logic [apllcr_pkg::ADDR_W-1:0] wr_addr;
	logic [apllcr_pkg::DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic [1:0] wr_resp;
	logic [apllcr_pkg::DATA_W-1:0] rd_data;
	logic [1:0] rd_resp;
	apllcr_pkg::apllcr_sel_e wsel;
	apllcr_pkg::apllcr_sel_e rsel;

	apllcr_wr_join u_wr (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.wr_resp(wr_resp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb)
	);

	apllcr_rd_port u_rd (
		.aclk(aclk),
		.aresetn(aresetn),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.rd_resp(rd_resp)
	);

	assign wsel = apllcr_pkg::apllcr_decode(wr_addr);
	assign rsel = apllcr_pkg::apllcr_decode(araddr);

	// Only byte lane 0 carries a register; a write with that lane off changes nothing.
	always_comb begin
		next_st = st;
		wr_resp = (wsel == apllcr_pkg::SEL_NONE) ? apllcr_pkg::RESP_SLVERR : apllcr_pkg::RESP_OKAY;
		if (wr_en && wr_strb[0]) begin
			case (wsel)
				apllcr_pkg::SEL_LOOP: begin
					next_st.pump = wr_data[apllcr_pkg::POS_PUMP +: 3];
					next_st.res = wr_data[apllcr_pkg::POS_RES +: 2];
					next_st.cap = wr_data[apllcr_pkg::POS_CAP +: 2];
					next_st.pole = wr_data[apllcr_pkg::POS_POLE];
				end
				// mode byte; reserved bits are dropped.
				apllcr_pkg::SEL_MODE: begin
					next_st.tdc_off = wr_data[apllcr_pkg::POS_TDC];
					next_st.xo = wr_data[apllcr_pkg::POS_XO];
					next_st.cntw = wr_data[apllcr_pkg::POS_CNTW];
					next_st.man = wr_data[apllcr_pkg::POS_MAN];
				end
				apllcr_pkg::SEL_VCO: begin
					next_st.osc = wr_data[apllcr_pkg::POS_OSC +: 3];
					next_st.code = wr_data[apllcr_pkg::POS_CODE +: 5];
				end
				default: begin
				end
			endcase
		end
		next_st.pump_steps = 4'({1'b0, next_st.pump} + 4'h1);
		next_st.tdc_en = !next_st.tdc_off;
		next_st.jit_en = !next_st.xo;
		next_st.lock_bits = next_st.cntw ? apllcr_pkg::LOCK_BITS_NARROW : apllcr_pkg::LOCK_BITS_WIDE;
		next_st.osc_second = next_st.osc == apllcr_pkg::OSC_SECOND;
		next_st.osc_bad = next_st.osc > apllcr_pkg::OSC_SECOND;
		// manual code only in manual mode.
		next_st.code_force = next_st.man ? next_st.code : 5'h00;
	end

	// Reserved bits and the reserved byte read as zero.
	always_comb begin
		rd_data = '0;
		rd_resp = apllcr_pkg::RESP_OKAY;
		case (rsel)
			apllcr_pkg::SEL_LOOP: begin
				rd_data[7:0] = {st.pump, st.res, st.cap, st.pole};
			end
			apllcr_pkg::SEL_MODE: begin
				rd_data[apllcr_pkg::POS_TDC] = st.tdc_off;
				rd_data[apllcr_pkg::POS_XO] = st.xo;
				rd_data[apllcr_pkg::POS_CNTW] = st.cntw;
				rd_data[apllcr_pkg::POS_MAN] = st.man;
			end
			apllcr_pkg::SEL_VCO: begin
				rd_data[7:0] = {st.osc, st.code};
			end
			apllcr_pkg::SEL_STATUS: begin
				rd_data[apllcr_pkg::POS_ST_MAN] = st.man;
				rd_data[apllcr_pkg::POS_ST_XO] = st.xo;
				rd_data[apllcr_pkg::POS_ST_OSCBAD] = st.osc_bad;
			end
			apllcr_pkg::SEL_RSVD: begin
			end
			default: begin
				rd_resp = apllcr_pkg::RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign pump_current_sel = st.pump;
	assign pump_current_steps = st.pump_steps;
	assign filter_series_res_sel = st.res;
	assign filter_par_cap_sel = st.cap;
	assign second_pole_sel = st.pole;
	assign time_digitizer_off = st.tdc_off;
	assign time_digitizer_en = st.tdc_en;
	assign crystal_only_synth = st.xo;
	assign jitter_atten_en = st.jit_en;
	assign lock_counter_width = st.cntw;
	assign lock_count_bits = st.lock_bits;
	assign lock_manual_override = st.man;
	assign manual_osc_pick = st.osc;
	assign osc_second_sel = st.osc_second;
	assign osc_reserved = st.osc_bad;
	assign manual_lock_code = st.code;
	assign lock_code_force = st.code_force;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	reset_defaults_a: assert property (
		$rose(aresetn) |-> pump_current_sel == 3'h4 && filter_series_res_sel == 2'h1
			&& filter_par_cap_sel == 2'h1 && second_pole_sel && !time_digitizer_off
			&& !crystal_only_synth && lock_counter_width && !lock_manual_override
			&& manual_osc_pick == 3'h1 && manual_lock_code == 5'h0b)
		else $error("Fields not at default after reset.");

	loop_write_a: assert property (
		wr_en && wr_strb[0] && wsel == apllcr_pkg::SEL_LOOP |=>
			{pump_current_sel, filter_series_res_sel, filter_par_cap_sel, second_pole_sel}
			== $past(wr_data[7:0]))
		else $error("Loop filter byte not stored at its positions.");

	code_write_a: assert property (
		wr_en && wr_strb[0] && wsel == apllcr_pkg::SEL_VCO |=>
			manual_lock_code == $past(wr_data[4:0]) && manual_osc_pick == $past(wr_data[7:5]))
		else $error("Oscillator byte not stored at its positions.");

	fields_hold_a: assert property (
		!(wr_en && wr_strb[0]) |=> $stable(pump_current_sel) && $stable(manual_lock_code)
			&& $stable(lock_manual_override) && $stable(filter_series_res_sel))
		else $error("Field changed without a write.");

	pump_steps_a: assert property (
		pump_current_steps == 4'({1'b0, pump_current_sel} + 4'h1))
		else $error("Pump step count does not follow the code.");

	digitizer_en_a: assert property (
		wr_en && wr_strb[0] && wsel == apllcr_pkg::SEL_MODE |=>
			time_digitizer_en == !$past(wr_data[4]))
		else $error("Digitizer enable does not follow its off bit.");

	synth_mode_a: assert property (
		jitter_atten_en != crystal_only_synth)
		else $error("Translate and crystal-only modes both active.");

	lock_width_a: assert property (
		lock_count_bits == (lock_counter_width ? 5'h10 : 5'h14))
		else $error("Lock accumulator length wrong.");

	manual_force_a: assert property (
		lock_code_force == (lock_manual_override ? manual_lock_code : 5'h00))
		else $error("Manual lock code applied outside manual mode.");

	osc_decode_a: assert property (
		osc_second_sel == (manual_osc_pick == 3'h1) && osc_reserved == (manual_osc_pick >= 3'h2))
		else $error("Oscillator selection decoded wrongly.");

	unmapped_read_a: assert property (
		rd_en && rsel == apllcr_pkg::SEL_NONE |=> rvalid && rresp == 2'h2)
		else $error("Unmapped read not answered with an error.");

	mode_read_a: assert property (
		rd_en && rsel == apllcr_pkg::SEL_MODE |=> rvalid && rdata[7:5] == 3'h0 && rdata[2] == 1'b0
			&& rdata[4] == $past(time_digitizer_off) && rdata[0] == $past(lock_manual_override))
		else $error("Mode byte reads back wrongly.");

	mode_write_a: assert property (
		wr_en && wr_strb[0] && wsel == apllcr_pkg::SEL_MODE |=>
			crystal_only_synth == $past(wr_data[3]) && lock_manual_override == $past(wr_data[0])
			&& lock_counter_width == $past(wr_data[1]) && time_digitizer_off == $past(wr_data[4]))
		else $error("Mode byte not stored at its positions.");

	write_error_a: assert property (
		wr_en && wsel == apllcr_pkg::SEL_NONE |=> bvalid && bresp == 2'h2)
		else $error("Unmapped write not answered with an error.");

	rsvd_read_a: assert property (
		rd_en && rsel == apllcr_pkg::SEL_RSVD |=> rvalid && rdata == 32'h0 && rresp == 2'h0)
		else $error("Reserved byte does not read as zero.");

	loop_write_c: cover property (wr_en && wsel == apllcr_pkg::SEL_LOOP);
	manual_mode_c: cover property ($rose(lock_manual_override));
	crystal_only_c: cover property ($rose(crystal_only_synth) ##[1:20] rvalid);
	status_read_c: cover property (rd_en && rsel == apllcr_pkg::SEL_STATUS);
endmodule // apllcr_regs

/* tb/apllcr_regs_tb.sv */
// Self-checking bench for the analog PLL control register bank over AXI4-Lite.
module apllcr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_LOOP = {apllcr_pkg::IDX_LOOP_CFG, 2'h0};
	localparam logic [11:0] A_MODE = {apllcr_pkg::IDX_MODE_CFG, 2'h0};
	localparam logic [11:0] A_OSC = {apllcr_pkg::IDX_VCO_CFG, 2'h0};
	localparam logic [11:0] A_RSVD = {apllcr_pkg::IDX_RSVD, 2'h0};
	localparam logic [1:0] OK = apllcr_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = apllcr_pkg::RESP_SLVERR;
	// The ceiling leaves a wide margin over the roughly 150 cycles the tests need.
	localparam int MAX_CYCLES = 5000;
	logic aclk, aresetn;
	logic [apllcr_pkg::ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [apllcr_pkg::DATA_W-1:0] wdata, rdata;
	logic [3:0] wstrb, pump_current_steps;
	logic [1:0] bresp, rresp, filter_series_res_sel, filter_par_cap_sel;
	logic [2:0] pump_current_sel, manual_osc_pick;
	logic second_pole_sel, time_digitizer_off, time_digitizer_en, crystal_only_synth, jitter_atten_en;
	logic lock_counter_width, lock_manual_override, osc_second_sel, osc_reserved;
	logic [4:0] lock_count_bits, manual_lock_code, lock_code_force;
	logic [7:0] v;
	int n_mismatch, check_count, cycles;

	apllcr_regs dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .pump_current_sel(pump_current_sel),
		.pump_current_steps(pump_current_steps), .filter_series_res_sel(filter_series_res_sel),
		.filter_par_cap_sel(filter_par_cap_sel), .second_pole_sel(second_pole_sel),
		.time_digitizer_off(time_digitizer_off), .time_digitizer_en(time_digitizer_en),
		.crystal_only_synth(crystal_only_synth), .jitter_atten_en(jitter_atten_en),
		.lock_counter_width(lock_counter_width), .lock_count_bits(lock_count_bits),
		.lock_manual_override(lock_manual_override), .manual_osc_pick(manual_osc_pick),
		.osc_second_sel(osc_second_sel), .osc_reserved(osc_reserved), .manual_lock_code(manual_lock_code),
		.lock_code_force(lock_code_force)
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic stop_test;
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		cycles = 0;
		forever @(posedge aclk) begin
			cycles++;
			if (cycles == MAX_CYCLES) begin
				n_mismatch++;
				$display("Error watchdog expected finish seen %0d cycles", cycles);
				stop_test();
			end
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// The request is held until its own ready is seen at an edge; each channel lets go independently.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		bit done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				bready <= 1'b0;
				chk("bresp", 32'(er), 32'(bresp));
			end
		end
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
		bit done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1'b1;
				rready <= 1'b0;
				chk(nm, exp, rdata);
				chk("rresp", 32'(er), 32'(rresp));
			end
		end
	endtask

	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic chk_defaults;
		rd_chk("loop", A_LOOP, {24'h0, apllcr_pkg::RST_PUMP, apllcr_pkg::RST_RES, apllcr_pkg::RST_CAP,
			apllcr_pkg::RST_POLE}, OK);
		rd_chk("mode", A_MODE, {27'h0, apllcr_pkg::RST_TDC, apllcr_pkg::RST_XO, 1'h0, apllcr_pkg::RST_CNTW,
			apllcr_pkg::RST_MAN}, OK);
		rd_chk("osc", A_OSC, {24'h0, apllcr_pkg::RST_OSC, apllcr_pkg::RST_CODE}, OK);
		rd_chk("rsvd", A_RSVD, 32'h0, OK);
		chk("steps", 32'h5, 32'(pump_current_steps));
		chk("tdc_en", 32'h1, 32'(time_digitizer_en));
		chk("jit_en", 32'h1, 32'(jitter_atten_en));
		chk("lock_bits", 32'h10, 32'(lock_count_bits));
		chk("osc_second", 32'h1, 32'(osc_second_sel));
		chk("force", 32'h0, 32'(lock_code_force));
		chk("osc_pick", 32'h1, 32'(manual_osc_pick));
		chk("code", 32'h0b, 32'(manual_lock_code));
		chk("osc_rsvd", 32'h0, 32'(osc_reserved));
		chk("flags", 32'h2, {28'h0, time_digitizer_off, crystal_only_synth, lock_counter_width,
			lock_manual_override});
	endtask

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		n_mismatch = 0;
		check_count = 0;
		do_reset();
		chk_defaults();
		$display("Test reset_defaults done");
		// Every pump code, with the filter fields varied alongside.
		for (int c = 0; c < 8; c++) begin
			v = {c[2:0], c[1:0], ~c[1:0], c[0]};
			axi_wr(A_LOOP, {24'h0, v}, 4'h1, OK);
			chk("pump", 32'(c), 32'(pump_current_sel));
			chk("steps", 32'(c + 1), 32'(pump_current_steps));
			chk("res", 32'(c[1:0]), 32'(filter_series_res_sel));
			chk("cap", {30'h0, ~c[1:0]}, 32'(filter_par_cap_sel));
			chk("pole", 32'(c[0]), 32'(second_pole_sel));
			rd_chk("loop", A_LOOP, {24'h0, v}, OK);
		end
		$display("Test loop_fields done");
		axi_wr(A_OSC, 32'h15, 4'h1, OK);
		chk("osc_second", 32'h0, 32'(osc_second_sel));
		chk("force", 32'h0, 32'(lock_code_force));
		chk("osc_pick", 32'h0, 32'(manual_osc_pick));
		chk("code", 32'h15, 32'(manual_lock_code));
		// freerun lives in the digital loop block, which software programs alongside.
		axi_wr(A_MODE, 32'h19, 4'h1, OK);
		chk("flags", 32'hd, {28'h0, time_digitizer_off, crystal_only_synth, lock_counter_width,
			lock_manual_override});
		chk("tdc_en", 32'h0, 32'(time_digitizer_en));
		chk("jit_en", 32'h0, 32'(jitter_atten_en));
		chk("lock_bits", 32'h14, 32'(lock_count_bits));
		chk("force", 32'h15, 32'(lock_code_force));
		rd_chk("mode", A_MODE, 32'h19, OK);
		axi_wr(A_OSC, 32'h4a, 4'h1, OK);
		chk("osc_rsvd", 32'h1, 32'(osc_reserved));
		chk("osc_second", 32'h0, 32'(osc_second_sel));
		rd_chk("status", 12'h200, 32'h7, OK);
		axi_wr(A_MODE, 32'h02, 4'h1, OK);
		chk("lock_bits", 32'h10, 32'(lock_count_bits));
		chk("force", 32'h0, 32'(lock_code_force));
		chk("tdc_en", 32'h1, 32'(time_digitizer_en));
		chk("flags", 32'h2, {28'h0, time_digitizer_off, crystal_only_synth, lock_counter_width,
			lock_manual_override});
		rd_chk("status", 12'h200, 32'h4, OK);
		$display("Test mode_fields done");
		// Refused or masked writes must leave the stored byte alone.
		axi_wr(A_LOOP, 32'h1234_566d, 4'h1, OK);
		axi_wr(A_LOOP, 32'h0000_0012, 4'h0, OK);
		axi_wr(12'h1b0, 32'h0000_0000, 4'h1, ERR);
		axi_wr(12'h1a1, 32'h0000_0012, 4'h1, ERR);
		axi_wr(A_RSVD, 32'h0000_0000, 4'h1, OK);
		rd_chk("loop", A_LOOP, 32'h6d, OK);
		rd_chk("unmapped", 12'h1b0, 32'h0, ERR);
		rd_chk("rsvd", A_RSVD, 32'h0, OK);
		$display("Test bad_access done");
		do_reset();
		chk_defaults();
		$display("Test second_reset done");
		stop_test();
	end
endmodule // apllcr_regs_tb
